// [core/spi_irq_dbg.v]
`timescale 1ns/10ps
`include "spi_irq_regs.vh"
module spi_irq_dbg #(
  parameter IS_PRIMARY = 1
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Interrupt lines
  output reg         primary_port_irq,
  output reg         secondary_port_irq,
  // Link pins
  input  wire        mosi_in,
  output wire        mosi_out,
  output wire        mosi_oe,
  input  wire        miso_in,
  output wire        miso_out,
  output wire        miso_oe,
  input  wire        serial_clock_in,
  output wire        serial_clock_out,
  output wire        serial_clock_oe,
  input  wire        slave_select_in_n,
  output wire        slave_select_out_n
);
  // Input synchronisers
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'h8;
      s2_q <= 4'h8;
    end else begin
      s1_q <= {slave_select_in_n, serial_clock_in, miso_in, mosi_in};
      s2_q <= s1_q;
    end
  end
  wire mosi_s = s2_q[0];
  wire miso_s = s2_q[1];
  wire sclk_s = s2_q[2];
  wire ss_s   = s2_q[3];

  // Registers
  reg [31:0] port_control_reg_q;
  reg [31:0] dma_config_reg_q;
  reg [15:0] dma_count_q;
  reg [7:0]  tx_buffer_q;
  reg [7:0]  rx_buffer_q;
  reg        rx_full_flag_q;
  reg        tx_full_q;
  reg        multimaster_error_q;
  reg        tx_underflow_q;
  reg        rx_overflow_q;
  reg        irq_latch_q;
  reg        core_irq_mask_q;
  reg        secondary_irq_mask_bit_q;
  reg        pend_q;

  wire [1:0] xfer_init_mode = port_control_reg_q[`CTL_MODE_LO+1:`CTL_MODE_LO];
  wire port_enable     = port_control_reg_q[`CTL_EN];
  wire master_select   = port_control_reg_q[`CTL_MS];
  wire loopback_enable = port_control_reg_q[`CTL_LPBK];
  wire rx_flush        = port_control_reg_q[`CTL_RXFL];
  wire tx_flush        = port_control_reg_q[`CTL_TXFL];
  wire dma_en          = dma_config_reg_q[`DC_EN];
  wire dma_direction   = dma_config_reg_q[`DC_RCV];
  wire dma_done_irq_en = dma_config_reg_q[`DC_DMA_DONE_IRQ_EN];
  wire dma_err_irq_en  = dma_config_reg_q[`DC_DMA_ERR_IRQ_EN];
  wire dma_chain_en    = dma_config_reg_q[`DC_CHEN];
  wire dma_per_block   = dma_config_reg_q[`DC_PCI];
  wire dma_underflow_flag = dma_config_reg_q[`DC_UNF];
  wire dma_overflow_flag  = dma_config_reg_q[`DC_OVF];
  wire dma_mode = dma_en && xfer_init_mode == `MODE_DMA;

  // APB decode
  wire acc  = psel & penable & pready;
  wire wr   = acc & pwrite;
  wire rd   = acc & ~pwrite;
  wire w_ctl = wr && paddr == `OFS_CTRL;
  wire w_st  = wr && paddr == `OFS_STAT;
  wire w_tx  = wr && paddr == `OFS_TXBUF;
  wire w_dc  = wr && paddr == `OFS_DMACFG;
  wire w_cnt = wr && paddr == `OFS_DMACNT;
  wire w_irq = wr && paddr == `OFS_IRQ;
  wire r_rx  = rd && paddr == `OFS_RXBUF;
  wire st_clr = w_st && (pwdata[`ST_MME] | pwdata[`ST_TX_UNDERFLOW] | pwdata[`ST_RX_OVERFLOW]);
  wire dc_flush = w_dc && pwdata == `DC_FLUSH_VAL;

  // Shifter link
  wire       busy;
  wire       loaded;
  wire       done;
  wire [7:0] rx_word;
  wire       lpbk = port_enable & master_select & loopback_enable;
  wire       sin = !master_select ? mosi_s : (lpbk ? mosi_out : miso_s);
  wire       run = port_enable & ~tx_flush & ~rx_flush;
  wire       dma_go = dma_mode && dma_count_q != 16'h0000 &&
                      (dma_direction ? ~rx_full_flag_q : tx_full_q);
  wire       start = master_select & ~busy & (pend_q | dma_go);

  spi_shifter u_shift (
    .clock    (clock),
    .rst_n    (rst_n),
    .enable   (run),
    .master   (master_select),
    .start    (start),
    .tx_word  (tx_buffer_q),
    .sin      (sin),
    .sclk_s   (sclk_s),
    .ss_s     (ss_s),
    .busy     (busy),
    .loaded   (loaded),
    .done     (done),
    .rx_word  (rx_word),
    .mosi_out (mosi_out),
    .mosi_oe  (mosi_oe),
    .miso_out (miso_out),
    .miso_oe  (miso_oe),
    .sclk_out (serial_clock_out),
    .sclk_oe  (serial_clock_oe),
    .ss_out_n (slave_select_out_n)
  );

  // Events
  wire unf_evt  = loaded & ~tx_full_q;
  wire ovf_evt  = done & rx_full_flag_q;
  wire mme_evt  = port_enable & master_select & ~ss_s;
  wire slv_dma  = dma_mode & ~master_select;
  wire set_dunf = slv_dma & ~dma_direction & unf_evt;
  wire set_dovf = slv_dma & dma_direction & ovf_evt;
  wire cnt_zero = dma_mode && done && dma_count_q == 16'h0001;
  wire done_irq = cnt_zero & dma_done_irq_en & (~dma_chain_en | dma_per_block);
  wire err_irq  = dma_err_irq_en & (mme_evt | (unf_evt & ~dma_direction) |
                  (ovf_evt & dma_direction));
  wire flag_irq = dma_underflow_flag | dma_overflow_flag | set_dunf | set_dovf;
  wire buf_irq  = port_enable & ~dma_mode &
                  ((xfer_init_mode == `MODE_RX) ? rx_full_flag_q :
                   (xfer_init_mode == `MODE_TX) ? ~tx_full_q : 1'b0);
  wire dma_irq  = dma_mode & (done_irq | err_irq | flag_irq);
  wire irq_set  = buf_irq | dma_irq | (~dma_mode & flag_irq);

  // Control registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_control_reg_q       <= `CTRL_RST;
      core_irq_mask_q          <= 1'b0;
      secondary_irq_mask_bit_q <= 1'b0;
      pend_q                   <= 1'b0;
    end else begin
      if (w_ctl) port_control_reg_q <= pwdata;
      if (w_irq) begin
        core_irq_mask_q          <= pwdata[`IRQ_HI_MASK];
        secondary_irq_mask_bit_q <= pwdata[`IRQ_LO_MASK];
      end
      if (start || !run || !master_select) pend_q <= 1'b0;
      else if ((r_rx && xfer_init_mode == `MODE_RX) ||
               (w_tx && xfer_init_mode == `MODE_TX)) pend_q <= 1'b1;
    end
  end

  // DMA configuration and count
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dma_config_reg_q <= 32'h0000_0000;
      dma_count_q      <= 16'h0000;
    end else begin
      if (dc_flush) begin
        dma_config_reg_q <= 32'h0000_0000;
        dma_count_q      <= 16'h0000;
      end else begin
        if (w_dc) begin
          dma_config_reg_q[5:0] <= pwdata[5:0];
          dma_config_reg_q[`DC_UNF] <= set_dunf;
          dma_config_reg_q[`DC_OVF] <= set_dovf;
        end else if (st_clr) begin
          dma_config_reg_q[`DC_UNF] <= set_dunf;
          dma_config_reg_q[`DC_OVF] <= set_dovf;
        end else begin
          if (set_dunf) dma_config_reg_q[`DC_UNF] <= 1'b1;
          if (set_dovf) dma_config_reg_q[`DC_OVF] <= 1'b1;
        end
        if (w_cnt) dma_count_q <= pwdata[15:0];
        else if (dma_mode && done && dma_count_q != 16'h0000)
          dma_count_q <= dma_count_q - 16'h0001;
      end
    end
  end

  // Data buffers and status
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_q         <= 8'h00;
      rx_buffer_q         <= 8'h00;
      tx_full_q           <= 1'b0;
      rx_full_flag_q      <= 1'b0;
      multimaster_error_q <= 1'b0;
      tx_underflow_q      <= 1'b0;
      rx_overflow_q       <= 1'b0;
    end else begin
      if (tx_flush) begin
        tx_buffer_q <= 8'h00;
        tx_full_q   <= 1'b0;
      end else if (w_tx) begin
        tx_buffer_q <= pwdata[7:0];
        tx_full_q   <= 1'b1;
      end else if (loaded) begin
        tx_full_q <= 1'b0;
      end
      if (rx_flush) begin
        rx_buffer_q    <= 8'h00;
        rx_full_flag_q <= 1'b0;
      end else if (done && !rx_full_flag_q) begin
        rx_buffer_q    <= rx_word;
        rx_full_flag_q <= 1'b1;
      end else if (r_rx) begin
        rx_full_flag_q <= 1'b0;
      end
      if (mme_evt) multimaster_error_q <= 1'b1;
      else if (w_st && pwdata[`ST_MME]) multimaster_error_q <= 1'b0;
      if (unf_evt) tx_underflow_q <= 1'b1;
      else if (w_st && pwdata[`ST_TX_UNDERFLOW]) tx_underflow_q <= 1'b0;
      if (ovf_evt) rx_overflow_q <= 1'b1;
      else if (w_st && pwdata[`ST_RX_OVERFLOW]) rx_overflow_q <= 1'b0;
    end
  end

  // Interrupt latch and gated lines
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_latch_q        <= 1'b0;
      primary_port_irq   <= 1'b0;
      secondary_port_irq <= 1'b0;
    end else begin
      if (irq_set) irq_latch_q <= 1'b1;
      else if (w_irq && pwdata[`IRQ_LATCH]) irq_latch_q <= 1'b0;
      primary_port_irq   <= (IS_PRIMARY != 0) & irq_latch_q & core_irq_mask_q;
      secondary_port_irq <= (IS_PRIMARY == 0) & irq_latch_q &
                            secondary_irq_mask_bit_q;
    end
  end

  // Read mux
  reg [31:0] rdata;
  reg        hit;
  always @* begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    case (paddr)
      `OFS_CTRL:   rdata = port_control_reg_q;
      `OFS_STAT: begin
        rdata[`ST_RXS]  = rx_full_flag_q;
        rdata[`ST_TXS]  = tx_full_q;
        rdata[`ST_MME]  = multimaster_error_q;
        rdata[`ST_TX_UNDERFLOW] = tx_underflow_q;
        rdata[`ST_RX_OVERFLOW] = rx_overflow_q;
      end
      `OFS_TXBUF:  rdata[7:0] = tx_buffer_q;
      `OFS_RXBUF:  rdata[7:0] = rx_buffer_q;
      `OFS_SHADOW: rdata[7:0] = rx_buffer_q;
      `OFS_DMACFG: rdata = dma_config_reg_q;
      `OFS_DMACNT: rdata[15:0] = dma_count_q;
      `OFS_IRQ: begin
        rdata[`IRQ_LATCH]   = irq_latch_q;
        rdata[`IRQ_HI_MASK] = core_irq_mask_q;
        rdata[`IRQ_LO_MASK] = secondary_irq_mask_bit_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // APB answer, one wait state
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= ~hit | (pwrite & paddr == `OFS_SHADOW);
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end
endmodule

// [core/spi_shifter.v]
`timescale 1ns/10ps
`include "spi_irq_regs.vh"
module spi_shifter (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // Control
  input  wire       enable,
  input  wire       master,
  input  wire       start,
  input  wire [7:0] tx_word,
  // Synced link inputs
  input  wire       sin,
  input  wire       sclk_s,
  input  wire       ss_s,
  // Events
  output reg        busy,
  output reg        loaded,
  output reg        done,
  output reg  [7:0] rx_word,
  // Pins
  output reg        mosi_out,
  output reg        mosi_oe,
  output reg        miso_out,
  output reg        miso_oe,
  output reg        sclk_out,
  output reg        sclk_oe,
  output reg        ss_out_n
);
  localparam S_IDLE = 3'h0;
  localparam S_LEAD = 3'h1;
  localparam S_SHFT = 3'h2;
  localparam S_LAG  = 3'h3;
  localparam S_GAP  = 3'h4;
  localparam S_SLV  = 3'h5;
  localparam integer HALF_I = `HALF_CYC - 1;
  localparam [7:0] HALF_M1 = HALF_I[7:0];
  reg [2:0] st_q;
  reg [7:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] rs_q;
  reg [2:0] nb_q;
  reg       sck_d1_q;
  wire      tick = (cnt_q == HALF_M1);
  wire      rise = sclk_s & ~sck_d1_q;
  wire      fall = ~sclk_s & sck_d1_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE; cnt_q <= 8'h00; sh_q <= 8'h00; rs_q <= 8'h00;
      nb_q <= 3'h0; sck_d1_q <= 1'b0; busy <= 1'b0; loaded <= 1'b0;
      done <= 1'b0; rx_word <= 8'h00; mosi_out <= 1'b0; mosi_oe <= 1'b0;
      miso_out <= 1'b0; miso_oe <= 1'b0; sclk_out <= 1'b0; sclk_oe <= 1'b0;
      ss_out_n <= 1'b1;
    end else begin
      sck_d1_q <= sclk_s;
      loaded <= 1'b0;
      done <= 1'b0;
      cnt_q <= (st_q == S_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;
      mosi_oe <= enable & master;
      sclk_oe <= enable & master;
      if (!enable) begin
        st_q <= S_IDLE; busy <= 1'b0; ss_out_n <= 1'b1;
        sclk_out <= 1'b0; miso_oe <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            nb_q <= 3'h0;
            if (master && start) begin
              st_q <= S_LEAD; busy <= 1'b1; loaded <= 1'b1;
              sh_q <= tx_word; mosi_out <= tx_word[7]; ss_out_n <= 1'b0;
            end else if (!master && !ss_s) begin
              st_q <= S_SLV; busy <= 1'b1; loaded <= 1'b1; miso_oe <= 1'b1;
              sh_q <= tx_word; miso_out <= tx_word[7];
            end
          end
          S_LEAD: if (tick) begin
            st_q <= S_SHFT; sclk_out <= 1'b1; rs_q <= {rs_q[6:0], sin};
          end
          S_SHFT: if (tick) begin
            sclk_out <= ~sclk_out;
            if (!sclk_out) rs_q <= {rs_q[6:0], sin};
            else if (nb_q == 3'h7) st_q <= S_LAG;
            else begin
              sh_q <= {sh_q[6:0], 1'b0}; mosi_out <= sh_q[6]; nb_q <= nb_q + 3'h1;
            end
          end
          S_LAG: if (tick) begin
            st_q <= S_GAP; ss_out_n <= 1'b1; done <= 1'b1; rx_word <= rs_q;
          end
          S_GAP: if (tick) begin
            st_q <= S_IDLE; busy <= 1'b0;
          end
          S_SLV: begin
            if (ss_s || master) begin
              st_q <= S_IDLE; busy <= 1'b0; miso_oe <= 1'b0;
            end else if (rise) begin
              nb_q <= nb_q + 3'h1;
              if (nb_q == 3'h7) begin
                done <= 1'b1; rx_word <= {rs_q[6:0], sin}; loaded <= 1'b1;
                sh_q <= tx_word; miso_out <= tx_word[7];
              end else rs_q <= {rs_q[6:0], sin};
            end else if (fall && nb_q != 3'h0) begin
              sh_q <= {sh_q[6:0], 1'b0}; miso_out <= sh_q[6];
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// [shared/spi_irq_regs.vh]
`ifndef SPI_IRQ_REGS_VH
`define SPI_IRQ_REGS_VH
`define OFS_CTRL     8'h00
`define OFS_STAT     8'h04
`define OFS_TXBUF    8'h08
`define OFS_RXBUF    8'h0c
`define OFS_SHADOW   8'h10
`define OFS_DMACFG   8'h14
`define OFS_DMACNT   8'h18
`define OFS_IRQ      8'h1c
`define CTL_MODE_LO  0
`define CTL_EN       2
`define CTL_MS       3
`define CTL_LPBK     4
`define CTL_RXFL     18
`define CTL_TXFL     19
`define ST_RXS       0
`define ST_TXS       1
`define ST_MME       2
`define ST_TX_UNDERFLOW      3
`define ST_RX_OVERFLOW      4
`define DC_EN        0
`define DC_RCV       1
`define DC_DMA_DONE_IRQ_EN     2
`define DC_DMA_ERR_IRQ_EN    3
`define DC_CHEN      4
`define DC_PCI       5
`define DC_UNF       8
`define DC_OVF       9
`define DC_FLUSH_VAL 32'h0000_0080
`define IRQ_LATCH    0
`define IRQ_HI_MASK  12
`define IRQ_LO_MASK  19
`define MODE_RX      2'h0
`define MODE_TX      2'h1
`define MODE_DMA     2'h2
`define CTRL_RST     32'h0000_0000
`define CLK_NS       5
`define HALF_NS      40
`define HALF_CYC     ((`HALF_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [tb/spi_far_slave.sv]
`timescale 1ns/10ps
module spi_far_slave #(
  parameter logic [7:0] REPLY = 8'ha6
) (
  // Link from master
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  // Reply and capture
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
  end
  // Load reply when selected
  always @(negedge ss_n) begin
    sh = REPLY;
    miso = REPLY[7];
  end
  // Capture on rise, MSB first
  always @(posedge sclk) begin
    if (!ss_n) got <= {got[6:0], mosi};
  end
  // Next bit on fall
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
  // Released line shows inverse
  always @(posedge ss_n) miso = ~miso;
endmodule

// [tb/spi_irq_checker.sv]
`timescale 1ns/10ps
`include "spi_irq_regs.vh"
module spi_irq_checker #(
  parameter IS_PRIMARY = 1
) (
  // Clock and reset
  input logic        clock,
  input logic        rst_n,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // Interrupts
  input logic        primary_port_irq,
  input logic        secondary_port_irq,
  // Link
  input logic        mosi_oe,
  input logic        serial_clock_oe,
  input logic        serial_clock_out,
  input logic        slave_select_out_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable && pready;

  chk_ready_one: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("ready not after one wait state");
  chk_unmapped_err: assert property (acc && paddr > `OFS_IRQ |-> pslverr)
    else $error("unmapped access without error");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  chk_sec_quiet: assert property (IS_PRIMARY == 1 |-> !secondary_port_irq)
    else $error("secondary line active on primary port");
  chk_mask_off: assert property (acc && pwrite && paddr == `OFS_IRQ
    && !pwdata[`IRQ_HI_MASK] |-> ##2 !primary_port_irq)
    else $error("masked interrupt still active");
  chk_off_quiet: assert property (acc && pwrite && paddr == `OFS_CTRL
    && pwdata == 32'h0 |-> ##2 !mosi_oe && !serial_clock_oe)
    else $error("disabled port still drives");
  chk_ss_gap: assert property ($rose(slave_select_out_n) |-> slave_select_out_n[*8])
    else $error("select high too short");
  chk_ss_lead: assert property ($fell(slave_select_out_n)
    |-> !serial_clock_out[*8] ##1 serial_clock_out)
    else $error("select lead not half period");
  chk_ss_lag: assert property ($rose(slave_select_out_n)
    |-> !$past(serial_clock_out, 8) && $past(serial_clock_out, 9))
    else $error("select lag not half period");
endmodule

bind spi_irq_dbg spi_irq_checker #(.IS_PRIMARY(IS_PRIMARY)) spi_irq_checker_inst (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .primary_port_irq(primary_port_irq), .secondary_port_irq(secondary_port_irq),
  .mosi_oe(mosi_oe), .serial_clock_oe(serial_clock_oe),
  .serial_clock_out(serial_clock_out), .slave_select_out_n(slave_select_out_n)
);

// [tb/testbench.sv]
`timescale 1ns/10ps
`include "spi_irq_regs.vh"
module testbench;
  localparam logic [7:0] REPLY = 8'ha6;
  logic        clock, rst_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready, pslverr, primary_port_irq, mosi_out, mosi_oe, miso;
  wire         sclk, ss_n;
  wire         sec_irq, slv_oe, slv_out, sclk_oe;
  logic        ext_sclk, ext_ss_n, ext_mosi;
  wire  [7:0]  got;
  int          failures, n_tests;

  spi_irq_dbg #(.IS_PRIMARY(1)) spi_irq_dbg_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .primary_port_irq(primary_port_irq), .secondary_port_irq(sec_irq),
    .mosi_in(ext_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso),
    .miso_out(slv_out), .miso_oe(slv_oe), .serial_clock_in(ext_sclk),
    .serial_clock_out(sclk), .serial_clock_oe(sclk_oe),
    .slave_select_in_n(ext_ss_n), .slave_select_out_n(ss_n));
  spi_far_slave #(.REPLY(REPLY)) spi_far_slave_inst (
    .sclk(sclk), .ss_n(ss_n), .mosi(mosi_out), .miso(miso), .got(got));

  always #2.5 clock = ~clock;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // Bounded wait on select level or interrupt
  task automatic wait_on(input bit irq, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((irq ? primary_port_irq : ss_n) !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    if ((irq ? primary_port_irq : ss_n) !== lvl) failures++;
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(`OFS_CTRL, r);
    check("ctrl reset", r, `CTRL_RST);
    rd(`OFS_IRQ, r);
    check("irq reset", r, 32'h0);
    check("select idle", {31'h0, ss_n}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, `OFS_SHADOW, 32'h55, r, e);
    check("shadow write error", {31'h0, e}, 32'h1);
    $display("end of reset test");
  endtask

  task automatic t_rx;
    logic [31:0] r;
    wr(`OFS_IRQ, 32'h0000_1000);
    wr(`OFS_CTRL, 32'h0000_000c);
    rd(`OFS_RXBUF, r);
    wait_on(1, 1'b1, 600);
    check("rx irq", {31'h0, primary_port_irq}, 32'h1);
    check("secondary quiet", {31'h0, sec_irq}, 32'h0);
    rd(`OFS_SHADOW, r);
    check("shadow data", r, {24'h0, REPLY});
    rd(`OFS_STAT, r);
    check("flags after shadow", r & 32'h9, 32'h9);
    wr(`OFS_STAT, 32'h0000_0008);
    rd(`OFS_STAT, r);
    check("underflow cleared", r & 32'h8, 32'h0);
    rd(`OFS_RXBUF, r);
    check("rx data", r, {24'h0, REPLY});
    rd(`OFS_STAT, r);
    check("rx flag cleared", r & 32'h1, 32'h0);
    wait_on(0, 1'b0, 50);
    wait_on(0, 1'b1, 400);
    wr(`OFS_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    check("port off", {30'h0, mosi_oe, sclk_oe}, 32'h0);
    rd(`OFS_RXBUF, r);
    wr(`OFS_IRQ, 32'h0000_0001);
    rd(`OFS_IRQ, r);
    check("latch cleared", r, 32'h0);
    $display("end of receive test");
  endtask

  task automatic t_loop;
    logic [31:0] r;
    wr(`OFS_CTRL, 32'h0000_001d);
    wr(`OFS_TXBUF, 32'h0000_003c);
    wait_on(0, 1'b0, 50);
    wait_on(0, 1'b1, 400);
    repeat (4) @(posedge clock);
    rd(`OFS_SHADOW, r);
    check("loop data", r, 32'h3c);
    check("pin data", {24'h0, got}, 32'h3c);
    rd(`OFS_STAT, r);
    check("rx full", r & 32'h1, 32'h1);
    wr(`OFS_CTRL, 32'h000c_001d);
    rd(`OFS_STAT, r);
    check("flushed status", r & 32'h3, 32'h0);
    rd(`OFS_SHADOW, r);
    check("flushed data", r, 32'h0);
    rd(`OFS_CTRL, r);
    check("flush held", r, 32'h000c_001d);
    wr(`OFS_CTRL, 32'h0);
    $display("end of loopback test");
  endtask

  task automatic t_dma;
    logic [31:0] r;
    wr(`OFS_IRQ, 32'h0000_1001);
    rd(`OFS_IRQ, r);
    check("latch clear mask kept", r, 32'h0000_1000);
    wr(`OFS_CTRL, 32'h0000_000e);
    wr(`OFS_DMACNT, 32'h1);
    wr(`OFS_DMACFG, 32'h0000_0007);
    wait_on(1, 1'b1, 1000);
    check("dma done irq", {31'h0, primary_port_irq}, 32'h1);
    rd(`OFS_DMACNT, r);
    check("count zero", r & 32'hffff, 32'h0);
    wr(`OFS_DMACFG, `DC_FLUSH_VAL);
    rd(`OFS_DMACFG, r);
    check("dma flushed", r, 32'h0);
    wr(`OFS_CTRL, 32'h0);
    $display("end of dma test");
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ext_mosi <= b[i];
      repeat (7) @(posedge clock);
      ext_sclk <= 1'b1;
      repeat (6) @(posedge clock);
      ext_sclk <= 1'b0;
    end
  endtask

  task automatic t_slave;
    logic [31:0] r;
    rd(`OFS_RXBUF, r);
    wr(`OFS_IRQ, 32'h0000_1001);
    wr(`OFS_CTRL, 32'h0000_0006);
    wr(`OFS_DMACFG, 32'h0000_0001);
    check("no irq before error", {31'h0, primary_port_irq}, 32'h0);
    ext_ss_n <= 1'b0;
    send_byte(8'h5a);
    check("slave drives miso", {30'h0, slv_oe, slv_out}, 32'h2);
    repeat (20) @(posedge clock);
    send_byte(8'hc3);
    repeat (7) @(posedge clock);
    ext_ss_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("error irq", {31'h0, primary_port_irq}, 32'h1);
    rd(`OFS_DMACFG, r);
    check("underflow flag", r & 32'h300, 32'h100);
    rd(`OFS_STAT, r);
    check("slave errors", r & 32'h18, 32'h18);
    rd(`OFS_RXBUF, r);
    check("slave data", r, 32'h5a);
    wr(`OFS_STAT, 32'h0000_0018);
    rd(`OFS_DMACFG, r);
    check("flag cleared", r & 32'h300, 32'h0);
    rd(`OFS_STAT, r);
    check("errors cleared", r & 32'h18, 32'h0);
    wr(`OFS_CTRL, 32'h0);
    $display("end of slave test");
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_sclk = 1'b0;
    ext_ss_n = 1'b1;
    ext_mosi = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_rx;
    t_loop;
    t_dma;
    t_slave;
    wrap_up;
  end

  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
